// *** clock_chain_pkg.sv ***
// package for the oscillator clock chain configuration block
// holds register indices, field positions, reset values, masks and the
// decoding functions shared by the top module and the factor decoder.
// assumes a single system clock and a plain address/strobe register port.
package clock_chain_pkg;

  // ==========================================================================
  // register port geometry
  // ==========================================================================
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;

  // register indices on the plain port
  localparam logic [1:0] IDX_CLOCK_DIVISOR_CONTROL = 2'h0;
  localparam logic [1:0] IDX_PLL_FEEDBACK_DIVISOR = 2'h1;
  localparam logic [1:0] IDX_CLOCK_CHAIN_STATUS = 2'h2;
  localparam logic [1:0] IDX_PLL_MULTIPLIER = 2'h3;

  // ==========================================================================
  // clock_divisor_control fields
  // ==========================================================================
  localparam int POS_RECOVER_ON_INTERRUPT = 15;
  localparam int POS_CPU_REDUCTION_LSB = 12;
  localparam int POS_REDUCTION_ENABLE = 11;
  localparam int POS_FAST_RC_POSTSCALE_LSB = 8;
  localparam int POS_PLL_OUTPUT_DIVIDER_LSB = 6;
  localparam int POS_PLL_INPUT_PRESCALER_LSB = 0;

  // bit 5 is unimplemented and reads zero
  localparam logic [15:0] CLOCK_DIVISOR_CONTROL_MASK = 16'hFFDF;
  localparam logic [15:0] CLOCK_DIVISOR_CONTROL_RESET = 16'h3040;

  // ==========================================================================
  // pll_feedback_divisor fields
  // ==========================================================================
  localparam int POS_PLL_FEEDBACK_LSB = 0;
  localparam logic [15:0] PLL_FEEDBACK_DIVISOR_MASK = 16'h01FF;
  localparam logic [15:0] PLL_FEEDBACK_DIVISOR_RESET = 16'h0030;

  // ==========================================================================
  // field codes and offsets of the divider arithmetic
  // ==========================================================================
  localparam logic [2:0] FAST_RC_CODE_DIV256 = 3'h7;
  localparam logic [8:0] FAST_RC_DIV256 = 9'h100;
  localparam logic [1:0] PLL_POST_CODE_DIV2 = 2'h0;
  localparam logic [1:0] PLL_POST_CODE_DIV4 = 2'h1;
  localparam logic [1:0] PLL_POST_CODE_RESERVED = 2'h2;
  localparam logic [1:0] PLL_POST_CODE_DIV8 = 2'h3;
  localparam logic [3:0] PLL_POST_DIV2 = 4'h2;
  localparam logic [3:0] PLL_POST_DIV4 = 4'h4;
  localparam logic [3:0] PLL_POST_DIV8 = 4'h8;
  localparam logic [5:0] PLL_PRESCALE_OFFSET = 6'h02;
  localparam logic [9:0] PLL_FEEDBACK_OFFSET = 10'h002;

  // divide ratio 2^code, used by both the reduction and postscale paths
  function automatic logic [8:0] pow2_ratio(input logic [2:0] code);
    pow2_ratio = 9'h001 << code;
  endfunction

  // output divider decode; reserved code gives zero
  function automatic logic [3:0] post_ratio(input logic [1:0] code);
    case (code)
      PLL_POST_CODE_DIV2: post_ratio = PLL_POST_DIV2;
      PLL_POST_CODE_DIV4: post_ratio = PLL_POST_DIV4;
      PLL_POST_CODE_DIV8: post_ratio = PLL_POST_DIV8;
      default: post_ratio = 4'h0;
    endcase
  endfunction

endpackage

// *** strobe_divider.sv ***
// strobe divider: one-cycle tick every div_ratio clocks
// assumes div_ratio is steady or changes rarely; a ratio of 0 or 1 ticks
// every cycle. a count left above a new, smaller ratio wraps at once.
`timescale 1ns/1ps
module strobe_divider #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [W-1:0] div_ratio,
  output logic tick
);

  logic [W-1:0] count;
  logic [W:0] count_plus;
  logic wrap;

  // wrap when the next count would reach the ratio
  assign count_plus = {1'b0, count} + {{W{1'b0}}, 1'b1};
  assign wrap = count_plus >= {1'b0, div_ratio};

  // counter and registered tick; halted divider restarts from zero
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      count <= '0;
      tick <= 1'b0;
    end else if (wrap) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count_plus[W-1:0];
      tick <= 1'b0;
    end
  end

endmodule

// *** clock_factor_decoder.sv ***
// clock factor decoder: turns the register fields into divide ratios
// purely combinational; the top module registers every result.
`timescale 1ns/1ps
module clock_factor_decoder
  import clock_chain_pkg::*;
(
  input wire logic [2:0] cpu_code,
  input wire logic reduction_on,
  input wire logic [2:0] frc_code,
  input wire logic [1:0] post_code,
  input wire logic [4:0] pre_code,
  input wire logic [8:0] feedback_code,
  output logic [8:0] cpu_ratio,
  output logic [8:0] frc_ratio,
  output logic [5:0] input_divide_factor,
  output logic [3:0] output_divide_factor,
  output logic post_reserved,
  output logic [9:0] pll_multiplier
);

  // reduction ratio applies only while enabled, else 1:1
  assign cpu_ratio = reduction_on ? pow2_ratio(cpu_code) : 9'h001;

  // postscaler: code 7 jumps to 256 rather than 128
  assign frc_ratio = (frc_code == FAST_RC_CODE_DIV256) ? FAST_RC_DIV256 : pow2_ratio(frc_code);

  // pll output divider with the reserved code flagged
  assign output_divide_factor = post_ratio(post_code);
  assign post_reserved = post_code == PLL_POST_CODE_RESERVED;

  // prescaler and feedback add two to the field value
  assign input_divide_factor = {1'b0, pre_code} + PLL_PRESCALE_OFFSET;
  assign pll_multiplier = {1'b0, feedback_code} + PLL_FEEDBACK_OFFSET;

endmodule

// *** clock_divider_pll_config.sv ***
// clock divider and pll configuration block, top level
// holds the clock divisor control and pll feedback divisor registers,
// recovers from clock reduction on interrupt, and derives clock enables
// and divide factors for the oscillator chain.
// assumes a single system clock, a same-clock interrupt event from the
// interrupt controller, and a master that keeps to one-cycle strobes.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module clock_divider_pll_config
  import clock_chain_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic interrupt_event,
  output logic cpu_clk_en,
  output logic frc_clk_en,
  output logic pll_ref_en,
  output logic pll_out_en,
  output logic reduction_active,
  output logic [8:0] cpu_ratio,
  output logic [8:0] frc_ratio,
  output logic [5:0] input_divide_factor,
  output logic [3:0] output_divide_factor,
  output logic [9:0] pll_multiplier,
  output logic pll_post_reserved
);

  // ==========================================================================
  // register storage
  // ==========================================================================
  logic [DATA_W-1:0] clock_divisor_control;
  logic [DATA_W-1:0] pll_feedback_divisor;
  logic [DATA_W-1:0] next_clock_divisor_control;
  logic [DATA_W-1:0] next_pll_feedback_divisor;

  // ==========================================================================
  // address decode
  // ==========================================================================
  logic hit_control;
  logic hit_feedback;
  logic hit_status;
  logic hit_multiplier;
  logic wr_control;
  logic wr_feedback;

  // all four indices are mapped, so every read returns a defined word;
  // status and multiplier have no write decode, so writes there fall away
  assign hit_control = addr == IDX_CLOCK_DIVISOR_CONTROL;
  assign hit_feedback = addr == IDX_PLL_FEEDBACK_DIVISOR;
  assign hit_status = addr == IDX_CLOCK_CHAIN_STATUS;
  assign hit_multiplier = addr == IDX_PLL_MULTIPLIER;
  assign wr_control = wr_en && hit_control;
  assign wr_feedback = wr_en && hit_feedback;

  // ==========================================================================
  // field views of the stored registers
  // ==========================================================================
  logic recover_on_interrupt;
  logic [2:0] cpu_clock_reduction_sel;
  logic clock_reduction_enable;
  logic [2:0] fast_rc_postscale_sel;
  logic [1:0] pll_output_divider;
  logic [4:0] pll_input_prescaler;
  logic [8:0] pll_feedback_value;

  assign recover_on_interrupt = clock_divisor_control[POS_RECOVER_ON_INTERRUPT];
  assign cpu_clock_reduction_sel = clock_divisor_control[POS_CPU_REDUCTION_LSB +: 3];
  assign clock_reduction_enable = clock_divisor_control[POS_REDUCTION_ENABLE];
  assign fast_rc_postscale_sel = clock_divisor_control[POS_FAST_RC_POSTSCALE_LSB +: 3];
  assign pll_output_divider = clock_divisor_control[POS_PLL_OUTPUT_DIVIDER_LSB +: 2];
  assign pll_input_prescaler = clock_divisor_control[POS_PLL_INPUT_PRESCALER_LSB +: 5];
  assign pll_feedback_value = pll_feedback_divisor[POS_PLL_FEEDBACK_LSB +: 9];

  // ==========================================================================
  // recovery on interrupt
  // ==========================================================================
  logic recover_now;
  logic [DATA_W-1:0] written_control;
  logic [DATA_W-1:0] recover_clear;

  // the recovery uses the stored enable of recovery; a write that sets the
  // bit in the same cycle as an interrupt arms it only for later interrupts
  assign recover_now = recover_on_interrupt && interrupt_event;

  // inverted one-hot mask that knocks out the reduction enable; only bit 11 is
  // touched, so the reduction code itself survives for the next enable
  assign recover_clear = ~(16'h0001 << POS_REDUCTION_ENABLE);

  // software write with unimplemented bit 5 forced to zero
  assign written_control = wr_control ? (wr_data & CLOCK_DIVISOR_CONTROL_MASK) : clock_divisor_control;

  // hardware recovery wins over a write in the same cycle, so an interrupt
  // that races a write setting the enable is never lost
  assign next_clock_divisor_control = recover_now ? (written_control & recover_clear) : written_control;

  // ==========================================================================
  // feedback divisor update
  // ==========================================================================
  // upper seven bits are stored as zero, so they can never read back set;
  // the mask is applied on the way in rather than on the read path
  assign next_pll_feedback_divisor = wr_feedback ? (wr_data & PLL_FEEDBACK_DIVISOR_MASK)
                                                 : pll_feedback_divisor;

  // ==========================================================================
  // register process
  // ==========================================================================
  // both registers take their power-on defaults on reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clock_divisor_control <= CLOCK_DIVISOR_CONTROL_RESET;
      pll_feedback_divisor <= PLL_FEEDBACK_DIVISOR_RESET;
    end else begin
      clock_divisor_control <= next_clock_divisor_control;
      pll_feedback_divisor <= next_pll_feedback_divisor;
    end
  end

  // ==========================================================================
  // factor decode
  // ==========================================================================
  logic [8:0] dec_cpu_ratio;
  logic [8:0] dec_frc_ratio;
  logic [5:0] dec_input_factor;
  logic [3:0] dec_output_factor;
  logic dec_post_reserved;
  logic [9:0] dec_multiplier;

  // decoding is shared by the status readback and the dividers
  clock_factor_decoder u_decoder (
    .cpu_code(cpu_clock_reduction_sel),
    .reduction_on(clock_reduction_enable),
    .frc_code(fast_rc_postscale_sel),
    .post_code(pll_output_divider),
    .pre_code(pll_input_prescaler),
    .feedback_code(pll_feedback_value),
    .cpu_ratio(dec_cpu_ratio),
    .frc_ratio(dec_frc_ratio),
    .input_divide_factor(dec_input_factor),
    .output_divide_factor(dec_output_factor),
    .post_reserved(dec_post_reserved),
    .pll_multiplier(dec_multiplier)
  );

  // ==========================================================================
  // output values at reset, derived from the register defaults
  // ==========================================================================
  // deriving them keeps the outputs and the stored defaults from drifting
  // apart if a default is changed; the fast rc shift assumes a default
  // postscale code below 7, which the power-on word keeps
  localparam logic [5:0] INPUT_FACTOR_AT_RESET =
    {1'b0, CLOCK_DIVISOR_CONTROL_RESET[POS_PLL_INPUT_PRESCALER_LSB +: 5]} + PLL_PRESCALE_OFFSET;
  localparam logic [9:0] MULTIPLIER_AT_RESET =
    {1'b0, PLL_FEEDBACK_DIVISOR_RESET[POS_PLL_FEEDBACK_LSB +: 9]} + PLL_FEEDBACK_OFFSET;
  localparam logic [8:0] FRC_RATIO_AT_RESET = 9'h001 << CLOCK_DIVISOR_CONTROL_RESET[POS_FAST_RC_POSTSCALE_LSB +: 3];
  localparam logic POST_RESERVED_AT_RESET =
    CLOCK_DIVISOR_CONTROL_RESET[POS_PLL_OUTPUT_DIVIDER_LSB +: 2] == PLL_POST_CODE_RESERVED;
  localparam logic REDUCTION_AT_RESET = CLOCK_DIVISOR_CONTROL_RESET[POS_REDUCTION_ENABLE];

  // ==========================================================================
  // registered factor outputs
  // ==========================================================================
  // factors follow the registers with one cycle of delay so every output
  // leaves a flip-flop; the values match the defaults right after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_ratio <= 9'h001; // enable resets clear, so 1:1
      frc_ratio <= FRC_RATIO_AT_RESET;
      input_divide_factor <= INPUT_FACTOR_AT_RESET;
      output_divide_factor <= PLL_POST_DIV4; // default output code 01
      pll_multiplier <= MULTIPLIER_AT_RESET;
      pll_post_reserved <= POST_RESERVED_AT_RESET;
      reduction_active <= REDUCTION_AT_RESET;
    end else begin
      cpu_ratio <= dec_cpu_ratio;
      frc_ratio <= dec_frc_ratio;
      input_divide_factor <= dec_input_factor;
      output_divide_factor <= dec_output_factor;
      pll_multiplier <= dec_multiplier;
      pll_post_reserved <= dec_post_reserved;
      reduction_active <= clock_reduction_enable;
    end
  end

  // ==========================================================================
  // clock enable dividers
  // ==========================================================================
  logic cpu_tick;
  logic frc_tick;
  logic ref_tick;
  logic out_tick;
  logic post_run;

  // the dividers take the decoded ratio straight from the decoder, so a new
  // ratio reaches the counters one cycle before the ratio outputs show it;
  // a count left above a smaller ratio wraps at once, giving one short period
  // processor clock enable relative to the peripheral clock
  strobe_divider #(
    .W(9)
  ) u_cpu_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(1'b1),
    .div_ratio(dec_cpu_ratio),
    .tick(cpu_tick)
  );

  // fast rc postscaler clock enable
  strobe_divider #(
    .W(9)
  ) u_frc_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(1'b1),
    .div_ratio(dec_frc_ratio),
    .tick(frc_tick)
  );

  // pll reference after the input prescaler
  strobe_divider #(
    .W(6)
  ) u_pre_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(1'b1),
    .div_ratio(dec_input_factor),
    .tick(ref_tick)
  );

  // the reserved output code has no defined ratio, so the output enable is
  // held off rather than guessing a divide value
  assign post_run = !dec_post_reserved;

  strobe_divider #(
    .W(4)
  ) u_post_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(post_run),
    .div_ratio(dec_output_factor),
    .tick(out_tick)
  );

  // enables leave flip-flops, one cycle behind the divider ticks; the extra
  // stage keeps every top-level output on a flip-flop at a cost of latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b0;
      frc_clk_en <= 1'b0;
      pll_ref_en <= 1'b0;
      pll_out_en <= 1'b0;
    end else begin
      cpu_clk_en <= cpu_tick;
      frc_clk_en <= frc_tick;
      pll_ref_en <= ref_tick;
      pll_out_en <= out_tick;
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] multiplier_word;
  logic [DATA_W-1:0] read_mux;

  // status: bit 4 reserved post code, bit 3 reduction live, bits 2:0 the
  // reduction code in force (zero while reduction is off)
  assign status_word = {11'h000, dec_post_reserved, clock_reduction_enable,
                        clock_reduction_enable ? cpu_clock_reduction_sel : 3'h0};
  assign multiplier_word = {6'h00, dec_multiplier};

  // stored registers read back as held, with unimplemented bits zero
  assign read_mux = hit_control    ? clock_divisor_control :
                    hit_feedback   ? pll_feedback_divisor :
                    hit_status     ? status_word :
                    hit_multiplier ? multiplier_word : 16'h0000;

  // read data stand for exactly the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      rd_data <= read_mux;
    end else begin
      rd_data <= 16'h0000;
    end
  end

endmodule

// *** clock_divider_pll_config_checker.sv ***
// checker for the clock divider and pll configuration block
// sees only the top module ports; bound in at the foot of this file.
`timescale 1ns/1ps
module clock_divider_pll_config_checker
  import clock_chain_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic interrupt_event,
  input wire logic cpu_clk_en,
  input wire logic frc_clk_en,
  input wire logic pll_ref_en,
  input wire logic pll_out_en,
  input wire logic reduction_active,
  input wire logic [8:0] cpu_ratio,
  input wire logic [8:0] frc_ratio,
  input wire logic [5:0] input_divide_factor,
  input wire logic [3:0] output_divide_factor,
  input wire logic [9:0] pll_multiplier,
  input wire logic pll_post_reserved
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // shadow of the recover bit, kept from the write traffic alone
  // ==========================================================================
  logic recover_shadow;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recover_shadow <= 1'b0;
    end else if (wr_en && addr == IDX_CLOCK_DIVISOR_CONTROL) begin
      recover_shadow <= wr_data[POS_RECOVER_ON_INTERRUPT];
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  a_recover_clears_reduction: assert property (
    interrupt_event && recover_shadow && reduction_active |-> ##2 !reduction_active)
    else $error("reduction still active after interrupt with recovery set");
  a_cpu_ratio_pow2: assert property ($onehot(cpu_ratio) && cpu_ratio <= 9'h080)
    else $error("cpu ratio not a power of two up to 128");
  a_frc_ratio_legal: assert property ($onehot(frc_ratio) && frc_ratio != 9'h080)
    else $error("fast rc ratio outside the legal set");
  a_post_reserved_flag: assert property (pll_post_reserved == (output_divide_factor == 4'h0))
    else $error("reserved flag and output factor disagree");
  a_reserved_stops_out: assert property (pll_post_reserved [*3] |-> !pll_out_en)
    else $error("pll output enable pulses on reserved code");
  a_prescale_range: assert property (input_divide_factor >= 6'h02 && input_divide_factor <= 6'h21)
    else $error("input divide factor out of range");
  a_mult_range: assert property (pll_multiplier >= 10'h002 && pll_multiplier <= 10'h201)
    else $error("pll multiplier out of range");
  a_feedback_upper_zero: assert property (
    $past(rd_en) && $past(addr) == IDX_PLL_FEEDBACK_DIVISOR |-> rd_data[15:9] == 7'h00)
    else $error("feedback upper bits read nonzero");
  a_ratio_one_when_off: assert property (!reduction_active |-> cpu_ratio == 9'h001)
    else $error("cpu ratio not 1 with reduction off");
  a_unit_ratio_every_cycle: assert property ((cpu_ratio == 9'h001) [*4] |-> cpu_clk_en)
    else $error("cpu enable missing at ratio 1");
  a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
    else $error("read data nonzero outside read cycle");

  // main scenarios reached
  c_recovery: cover property (interrupt_event && recover_shadow && reduction_active);
  c_reserved: cover property (pll_post_reserved);
  c_max_reduction: cover property (cpu_ratio == 9'h080);
endmodule

bind clock_divider_pll_config clock_divider_pll_config_checker chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .interrupt_event(interrupt_event),
  .cpu_clk_en(cpu_clk_en), .frc_clk_en(frc_clk_en), .pll_ref_en(pll_ref_en), .pll_out_en(pll_out_en),
  .reduction_active(reduction_active), .cpu_ratio(cpu_ratio), .frc_ratio(frc_ratio),
  .input_divide_factor(input_divide_factor), .output_divide_factor(output_divide_factor),
  .pll_multiplier(pll_multiplier), .pll_post_reserved(pll_post_reserved));

// *** clock_divider_pll_config_tb_top.sv ***
// self-checking testbench for the clock divider and pll configuration block
// drives the plain register port and the interrupt input directly.
`timescale 1ns/1ps
module clock_divider_pll_config_tb_top;
  import clock_chain_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic interrupt_event = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic cpu_clk_en, frc_clk_en, pll_ref_en, pll_out_en, reduction_active, pll_post_reserved;
  logic [8:0] cpu_ratio, frc_ratio;
  logic [5:0] input_divide_factor;
  logic [3:0] output_divide_factor;
  logic [9:0] pll_multiplier;
  int failures = 0;
  int samples_checked = 0;
  int n;

  always #10 clk = ~clk;

  clock_divider_pll_config dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .interrupt_event(interrupt_event), .cpu_clk_en(cpu_clk_en),
    .frc_clk_en(frc_clk_en), .pll_ref_en(pll_ref_en), .pll_out_en(pll_out_en),
    .reduction_active(reduction_active), .cpu_ratio(cpu_ratio), .frc_ratio(frc_ratio),
    .input_divide_factor(input_divide_factor), .output_divide_factor(output_divide_factor),
    .pll_multiplier(pll_multiplier), .pll_post_reserved(pll_post_reserved));

  // ==========================================================================
  // comparison, bus tasks and closing report
  // ==========================================================================
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one-cycle write strobe; an idle edge follows before the next access
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [15:0] exp, input string name);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(name, rd_data, exp);
  endtask

  // factor outputs lag the register by one cycle
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // cycles between two enable pulses; a missing pulse ends the run
  task automatic period(input int sel, output int cnt);
    int k;
    cnt = 0;
    for (k = 0; k < 2; k++) begin
      cnt = 0;
      do begin
        @(posedge clk);
        #1;
        cnt++;
        if (cnt > 600) begin
          failures++;
          wrap_up();
        end
      end while (!(sel == 0 ? cpu_clk_en : sel == 1 ? pll_out_en : sel == 2 ? frc_clk_en : pll_ref_en));
    end
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    logic [15:0] fb [5];
    logic [3:0] post_exp [4];
    fb = '{16'h0000, 16'h0001, 16'h0030, 16'h01FF, 16'hFFFF};
    post_exp = '{4'h2, 4'h4, 4'h0, 4'h8};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_CLOCK_DIVISOR_CONTROL, 16'h3040, "control reset");
    rd(IDX_PLL_FEEDBACK_DIVISOR, 16'h0030, "feedback reset");
    #1;
    check("cpu ratio reset", 16'(cpu_ratio), 16'h0001);
    check("frc ratio reset", 16'(frc_ratio), 16'h0001);
    check("post reset", 16'(output_divide_factor), 16'h0004);
    check("pre reset", 16'(input_divide_factor), 16'h0002);
    check("mult reset", 16'(pll_multiplier), 16'h0032);
    // unimplemented bit 5 drops writes
    wr(IDX_CLOCK_DIVISOR_CONTROL, 16'hFFFF);
    rd(IDX_CLOCK_DIVISOR_CONTROL, 16'hFFDF, "control all ones");
    // every reduction, postscale and low prescale code with reduction on
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CLOCK_DIVISOR_CONTROL, {1'b0, 3'(c), 1'b1, 3'(c), 2'b01, 1'b0, 5'(c)});
      settle();
      check("cpu ratio", 16'(cpu_ratio), 16'h0001 << c);
      check("frc ratio", 16'(frc_ratio), c == 7 ? 16'h0100 : 16'h0001 << c);
      check("pre factor", 16'(input_divide_factor), 16'(c + 2));
      if (c == 3) begin
        period(2, n);
        check("frc period", 16'(n), 16'h0008);
        period(3, n);
        check("ref period", 16'(n), 16'h0005);
      end
    end
    // every output divider code; field set to 7 but reduction off
    for (int p = 0; p < 4; p++) begin
      wr(IDX_CLOCK_DIVISOR_CONTROL, {4'h7, 4'h0, 2'(p), 1'b0, 5'h1F});
      settle();
      check("post factor", 16'(output_divide_factor), 16'(post_exp[p]));
      check("post reserved", 16'(pll_post_reserved), 16'(p == 2));
      check("pre max", 16'(input_divide_factor), 16'h0021);
      check("cpu ratio off", 16'(cpu_ratio), 16'h0001);
    end
    period(1, n);
    check("pll out period", 16'(n), 16'h0008);
    // feedback divisor boundaries and unimplemented upper bits
    foreach (fb[i]) begin
      wr(IDX_PLL_FEEDBACK_DIVISOR, fb[i]);
      rd(IDX_PLL_FEEDBACK_DIVISOR, fb[i] & 16'h01FF, "feedback read");
      settle();
      check("multiplier", 16'(pll_multiplier), 16'(fb[i][8:0]) + 16'h0002);
    end
    rd(IDX_PLL_MULTIPLIER, 16'h0201, "multiplier word");
    wr(IDX_PLL_MULTIPLIER, 16'hFFFF);
    rd(IDX_PLL_MULTIPLIER, 16'h0201, "multiplier after write");
    // reduction by 8 without recovery: an interrupt changes nothing
    wr(IDX_CLOCK_DIVISOR_CONTROL, 16'h3840);
    settle();
    period(0, n);
    check("cpu period", 16'(n), 16'h0008);
    @(posedge clk);
    interrupt_event <= 1'b1;
    @(posedge clk);
    interrupt_event <= 1'b0;
    rd(IDX_CLOCK_DIVISOR_CONTROL, 16'h3840, "no recovery");
    // recovery set: the interrupt clears the enable and restores 1:1
    wr(IDX_CLOCK_DIVISOR_CONTROL, 16'hB840);
    settle();
    check("reduction on", 16'(reduction_active), 16'h0001);
    rd(IDX_CLOCK_CHAIN_STATUS, 16'h000B, "status reduced");
    @(posedge clk);
    interrupt_event <= 1'b1;
    @(posedge clk);
    interrupt_event <= 1'b0;
    rd(IDX_CLOCK_DIVISOR_CONTROL, 16'hB040, "recovered control");
    settle();
    check("reduction off", 16'(reduction_active), 16'h0000);
    check("cpu ratio recovered", 16'(cpu_ratio), 16'h0001);
    rd(IDX_CLOCK_CHAIN_STATUS, 16'h0000, "status recovered");
    period(0, n);
    check("cpu period 1", 16'(n), 16'h0001);
    wrap_up();
  end
endmodule
